// ---- hw/dcf_pkg.sv ----
// constants, types and helpers shared by the dual-clock fifo design files
package dcf_pkg;

  // =====================================================================
  // geometry
  // =====================================================================
  localparam int          DCF_DW    = 9;
  localparam int          DCF_AW    = 14;
  localparam int          DCF_PW    = DCF_AW + 1;
  localparam int          DCF_TW    = 14;
  localparam logic [14:0] DCF_DEPTH = 15'h4000;
  localparam logic [14:0] DCF_HALF  = 15'h2000;

  // =====================================================================
  // threshold defaults and parallel load slots
  // =====================================================================
  localparam logic [13:0] DCF_THR_DEF_PAR = 14'h007f;
  localparam logic [13:0] DCF_THR_DEF_SER = 14'h03ff;
  localparam int          DCF_PAR_LO_W    = 9;
  localparam int          DCF_PAR_HI_W    = DCF_TW - DCF_PAR_LO_W;
  localparam logic [1:0]  DCF_SLOT_E_LO   = 2'h0;
  localparam logic [1:0]  DCF_SLOT_E_HI   = 2'h1;
  localparam logic [1:0]  DCF_SLOT_F_LO   = 2'h2;
  localparam logic [1:0]  DCF_SLOT_F_HI   = 2'h3;

  // =====================================================================
  // types
  // =====================================================================
  typedef struct packed {
    logic [DCF_TW-1:0] full_thr;
    logic [DCF_TW-1:0] empty_thr;
  } dcf_thr_t;

  typedef enum logic [0:0] {
    DCF_MODE_STD,
    DCF_MODE_FALL_THROUGH
  } dcf_mode_t;

  // =====================================================================
  // gray code helpers
  // =====================================================================
  function automatic logic [DCF_PW-1:0] dcf_bin2gray(input logic [DCF_PW-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [DCF_PW-1:0] dcf_gray2bin(input logic [DCF_PW-1:0] g);
    logic [DCF_PW-1:0] b;
    b = '0;
    for (int i = DCF_PW - 1; i >= 0; i--) begin
      b[i] = g[i] ^ ((i == DCF_PW - 1) ? 1'b0 : b[i+1]);
    end
    return b;
  endfunction

endpackage

// ---- hw/dcf_ram.sv ----
// storage array with registered read data
`timescale 1ns/100ps
module dcf_ram
  import dcf_pkg::*;
(
  input  wire logic              wclk,
  input  wire logic              we,
  input  wire logic [DCF_AW-1:0] waddr,
  input  wire logic [DCF_DW-1:0] wdata,
  input  wire logic              rclk,
  input  wire logic              rrst_n,
  input  wire logic              re,
  input  wire logic [DCF_AW-1:0] raddr,
  output logic      [DCF_DW-1:0] rdata_q
);

  logic [DCF_DW-1:0] mem [0:(1<<DCF_AW)-1];

  always_ff @(posedge wclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // read register doubles as the output register, cleared by reset
  always_ff @(posedge rclk or negedge rrst_n) begin
    if (!rrst_n) begin
      rdata_q <= '0;
    end else if (re) begin
      rdata_q <= mem[raddr];
    end
  end

endmodule

// ---- hw/dcf_top.sv ----
// dual-clock 9-bit fifo: read port, threshold programming and status flags
`timescale 1ns/100ps
module dcf_top
  import dcf_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              write_req_n,
  input  wire logic [DCF_DW-1:0] write_data,
  input  wire logic              threshold_load_n,
  input  wire logic              serial_prog_en_n,
  input  wire logic              fall_through,
  input  wire logic              read_clk,
  input  wire logic              read_req_n,
  input  wire logic              output_drive_n,
  output logic      [DCF_DW-1:0] read_data_out,
  output logic      [DCF_DW-1:0] read_data_oe,
  output logic                   empty_n,
  output logic                   full_n,
  output logic                   almost_empty_n,
  output logic                   almost_full_n,
  output logic                   half_full_n,
  output logic      [DCF_TW-1:0] empty_thr_out,
  output logic      [DCF_TW-1:0] full_thr_out
);

  // =====================================================================
  // write domain state
  // =====================================================================
  logic              strap_done_q;
  dcf_mode_t         mode_q;
  logic              serial_q;
  dcf_thr_t          thr_q;
  logic [1:0]        slot_q;
  logic [DCF_PW-1:0] wbin_q;
  logic [DCF_PW-1:0] wbin_d;
  logic [DCF_PW-1:0] wgray_q;
  logic [DCF_PW-1:0] rsync1_q;
  logic [DCF_PW-1:0] rsync2_q;
  logic              full_n_q;
  logic              af_n_q;
  logic              hf_n_q;
  logic              wr_ok;
  logic              fall_through_w;
  logic [DCF_PW-1:0] total_d;
  logic [DCF_PW-1:0] cap_w;
  logic [DCF_PW-1:0] af_lim;
  logic [DCF_PW-1:0] hf_lim;

  // =====================================================================
  // read domain state
  // =====================================================================
  logic [1:0]        rrst_q;
  logic              rrst_n;
  logic [DCF_PW-1:0] wsync1_q;
  logic [DCF_PW-1:0] wsync2_q;
  logic              msync1_q;
  logic              msync2_q;
  logic [DCF_TW-1:0] esync1_q;
  logic [DCF_TW-1:0] esync2_q;
  logic              odsync1_q;
  logic              odsync2_q;
  logic [DCF_PW-1:0] rbin_q;
  logic [DCF_PW-1:0] rbin_d;
  logic [DCF_PW-1:0] cgray_q;
  logic [DCF_PW-1:0] cons_d;
  logic              ov_q;
  logic              ov_d;
  logic              empty_n_q;
  logic              ae_n_q;
  logic [DCF_DW-1:0] oe_q;
  logic [DCF_PW-1:0] wbin_r;
  logic              mem_has;
  logic              fetch;
  logic [DCF_PW-1:0] occ_r;
  logic [DCF_PW-1:0] ae_lim;

  // =====================================================================
  // reset straps, caught on the first write edge after release
  // =====================================================================
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_q <= 1'b0;
      mode_q       <= DCF_MODE_STD;
      serial_q     <= 1'b1;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      mode_q       <= fall_through ? DCF_MODE_FALL_THROUGH : DCF_MODE_STD;
      serial_q     <= threshold_load_n;
    end
  end

  assign fall_through_w = (mode_q == DCF_MODE_FALL_THROUGH);

  // =====================================================================
  // threshold registers: defaults, serial shift, parallel slots
  // =====================================================================
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      thr_q <= '{full_thr: DCF_THR_DEF_SER, empty_thr: DCF_THR_DEF_SER};
    end else if (!strap_done_q) begin
      if (threshold_load_n) begin
        thr_q <= '{full_thr: DCF_THR_DEF_SER, empty_thr: DCF_THR_DEF_SER};
      end else begin
        thr_q <= '{full_thr: DCF_THR_DEF_PAR, empty_thr: DCF_THR_DEF_PAR};
      end
    end else if (!threshold_load_n) begin
      if (serial_q) begin
        if (!serial_prog_en_n) begin
          // fall-through pin doubles as the serial data input
          thr_q <= {fall_through, thr_q[2*DCF_TW-1:1]};
        end
      end else if (!write_req_n) begin
        case (slot_q)
          DCF_SLOT_E_LO: begin
            thr_q.empty_thr[DCF_PAR_LO_W-1:0] <= write_data;
          end
          DCF_SLOT_E_HI: begin
            thr_q.empty_thr[DCF_TW-1:DCF_PAR_LO_W] <= write_data[DCF_PAR_HI_W-1:0];
          end
          DCF_SLOT_F_LO: begin
            thr_q.full_thr[DCF_PAR_LO_W-1:0] <= write_data;
          end
          default: begin
            thr_q.full_thr[DCF_TW-1:DCF_PAR_LO_W] <= write_data[DCF_PAR_HI_W-1:0];
          end
        endcase
      end
    end
  end

  // parallel slot pointer restarts each time load is released
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      slot_q <= DCF_SLOT_E_LO;
    end else if (threshold_load_n || serial_q) begin
      slot_q <= DCF_SLOT_E_LO;
    end else if (!write_req_n) begin
      slot_q <= slot_q + 2'h1;
    end
  end

  // parallel readback of the offsets, always available
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      empty_thr_out <= DCF_THR_DEF_SER;
      full_thr_out  <= DCF_THR_DEF_SER;
    end else begin
      empty_thr_out <= thr_q.empty_thr;
      full_thr_out  <= thr_q.full_thr;
    end
  end

  // =====================================================================
  // write pointer; load low blocks writes, and in parallel mode steers them to the thresholds instead
  // =====================================================================
  assign wr_ok  = strap_done_q && threshold_load_n && !write_req_n && full_n_q;
  assign wbin_d = wr_ok ? wbin_q + 1'b1 : wbin_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wbin_q  <= '0;
      wgray_q <= '0;
    end else begin
      wbin_q  <= wbin_d;
      wgray_q <= dcf_bin2gray(wbin_d);
    end
  end

  // consumed-word pointer from the read side, two flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rsync1_q <= '0;
      rsync2_q <= '0;
    end else begin
      rsync1_q <= cgray_q;
      rsync2_q <= rsync1_q;
    end
  end

  // =====================================================================
  // write side flags; occupancy counts the output word in fall-through
  // =====================================================================
  assign total_d = wbin_d - dcf_gray2bin(rsync2_q);
  assign cap_w   = DCF_DEPTH + {{(DCF_PW-1){1'b0}}, fall_through_w};
  assign af_lim  = cap_w - {1'b0, thr_q.full_thr};
  assign hf_lim  = DCF_HALF + {{(DCF_PW-1){1'b0}}, fall_through_w};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      full_n_q <= 1'b1;
    end else begin
      full_n_q <= (total_d < cap_w);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      full_n <= 1'b1;
    end else if (fall_through_w) begin
      full_n <= !full_n_q;
    end else begin
      full_n <= full_n_q;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      af_n_q        <= 1'b1;
      almost_full_n <= 1'b1;
    end else begin
      af_n_q        <= (total_d < af_lim);
      almost_full_n <= af_n_q;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hf_n_q      <= 1'b1;
      half_full_n <= 1'b1;
    end else begin
      hf_n_q      <= (total_d <= hf_lim);
      half_full_n <= hf_n_q;
    end
  end

  // =====================================================================
  // read domain reset release and synchronisers
  // =====================================================================
  always_ff @(posedge read_clk or negedge rst_n) begin
    if (!rst_n) begin
      rrst_q <= 2'h0;
    end else begin
      rrst_q <= {rrst_q[0], 1'b1};
    end
  end

  assign rrst_n = rrst_q[1];

  always_ff @(posedge read_clk or negedge rrst_n) begin
    if (!rrst_n) begin
      wsync1_q  <= '0;
      wsync2_q  <= '0;
      msync1_q  <= 1'b0;
      msync2_q  <= 1'b0;
      esync1_q  <= DCF_THR_DEF_SER;
      esync2_q  <= DCF_THR_DEF_SER;
      odsync1_q <= 1'b1;
      odsync2_q <= 1'b1;
    end else begin
      wsync1_q  <= wgray_q;
      wsync2_q  <= wsync1_q;
      msync1_q  <= fall_through_w;
      msync2_q  <= msync1_q;
      // quasi-static offset, only changed while programming
      esync1_q  <= thr_q.empty_thr;
      esync2_q  <= esync1_q;
      odsync1_q <= output_drive_n;
      odsync2_q <= odsync1_q;
    end
  end

  // =====================================================================
  // read control: fetch from memory into the output register
  // =====================================================================
  assign wbin_r  = dcf_gray2bin(wsync2_q);
  assign mem_has = (wbin_r != rbin_q);

  // standard obeys its own empty flag; fall-through also refills an idle output
  assign fetch = msync2_q ? (mem_has && (!read_req_n || !ov_q))
                          : (empty_n_q && !read_req_n);
  assign rbin_d = fetch ? rbin_q + 1'b1 : rbin_q;

  always_comb begin
    ov_d = ov_q;
    if (fetch) begin
      ov_d = 1'b1;
    end else if (!read_req_n) begin
      ov_d = 1'b0;
    end
  end

  // words still owned by the reader are not free space for the writer
  assign cons_d = rbin_d - {{(DCF_PW-1){1'b0}}, (msync2_q & ov_d)};

  always_ff @(posedge read_clk or negedge rrst_n) begin
    if (!rrst_n) begin
      rbin_q  <= '0;
      ov_q    <= 1'b0;
      cgray_q <= '0;
    end else begin
      rbin_q  <= rbin_d;
      ov_q    <= ov_d;
      cgray_q <= dcf_bin2gray(cons_d);
    end
  end

  dcf_ram u_ram (
    .wclk    (mclk),
    .we      (wr_ok),
    .waddr   (wbin_q[DCF_AW-1:0]),
    .wdata   (write_data),
    .rclk    (read_clk),
    .rrst_n  (rrst_n),
    .re      (fetch),
    .raddr   (rbin_q[DCF_AW-1:0]),
    .rdata_q (read_data_out)
  );

  // =====================================================================
  // read side flags
  // =====================================================================
  always_ff @(posedge read_clk or negedge rrst_n) begin
    if (!rrst_n) begin
      empty_n_q <= 1'b0;
    end else if (msync2_q) begin
      empty_n_q <= !ov_d;
    end else begin
      empty_n_q <= (wbin_r != rbin_d);
    end
  end

  assign empty_n = empty_n_q;

  assign occ_r  = wbin_r - cons_d;
  assign ae_lim = {1'b0, esync2_q} + {{(DCF_PW-1){1'b0}}, msync2_q};

  always_ff @(posedge read_clk or negedge rrst_n) begin
    if (!rrst_n) begin
      ae_n_q <= 1'b0;
    end else begin
      ae_n_q <= (occ_r > ae_lim);
    end
  end

  assign almost_empty_n = ae_n_q;

  // data pin drive enable, one bit per data line
  always_ff @(posedge read_clk or negedge rrst_n) begin
    if (!rrst_n) begin
      oe_q <= '0;
    end else begin
      oe_q <= {DCF_DW{!odsync2_q}};
    end
  end

  assign read_data_oe = oe_q;

endmodule

// ---- verif/dcf_checker.sv ----
// concurrent checks on the dual-clock fifo top ports
`timescale 1ns/100ps
module dcf_checker
  import dcf_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic              threshold_load_n,
  input wire logic              serial_prog_en_n,
  input wire logic              fall_through,
  input wire logic              read_clk,
  input wire logic              read_req_n,
  input wire logic              output_drive_n,
  input wire logic [DCF_DW-1:0] read_data_out,
  input wire logic [DCF_DW-1:0] read_data_oe,
  input wire logic              empty_n,
  input wire logic              full_n,
  input wire logic              almost_empty_n,
  input wire logic              almost_full_n,
  input wire logic              half_full_n,
  input wire logic [DCF_TW-1:0] full_thr_out
);
  // ===================================================================
  // strap capture
  // ===================================================================
  logic       ft_q;
  logic       ser_q;
  logic [1:0] age_q;
  logic [2:0] rage_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      age_q <= 2'h0;
      ft_q  <= 1'b0;
      ser_q <= 1'b0;
    end else if (age_q != 2'h3) begin
      age_q <= age_q + 2'h1;
      if (age_q == 2'h0) begin
        ft_q  <= fall_through;
        ser_q <= threshold_load_n;
      end
    end
  end
  wire full_w = ft_q ? full_n : !full_n;
  wire up_w   = age_q == 2'h3;
  // read side settles late: reset release and mode both cross two flops
  always_ff @(posedge read_clk or negedge rst_n) begin
    if (!rst_n) begin
      rage_q <= 3'h0;
    end else if (rage_q != 3'h7) begin
      rage_q <= rage_q + 3'h1;
    end
  end
  wire up_r   = up_w && (rage_q == 3'h7);

  // ===================================================================
  // properties
  // ===================================================================
  property p_hold;
    @(posedge read_clk) disable iff (!rst_n)
      up_r && read_req_n && (!ft_q || !empty_n) |=> $stable(read_data_out);
  endproperty
  a_hold: assert property (p_hold) else $error("output word changed without read");
  property p_oe_on;
    @(posedge read_clk) disable iff (!rst_n) !output_drive_n [*6] |=> read_data_oe == '1;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("data pins not driven");
  property p_oe_off;
    @(posedge read_clk) disable iff (!rst_n) output_drive_n [*6] |=> read_data_oe == '0;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("data pins not released");
  property p_full_half;
    @(posedge mclk) disable iff (!rst_n) up_w && full_w [*2] |-> !half_full_n;
  endproperty
  a_full_half: assert property (p_full_half) else $error("full without half full");
  property p_full_almost;
    @(posedge mclk) disable iff (!rst_n) up_w && full_w [*3] |-> !almost_full_n;
  endproperty
  a_full_almost: assert property (p_full_almost) else $error("full without almost full");
  property p_thr_hold;
    @(posedge mclk) disable iff (!rst_n)
      (up_w && serial_prog_en_n && (ser_q || threshold_load_n)) [*3] |=> $stable(full_thr_out);
  endproperty
  a_thr_hold: assert property (p_thr_hold) else $error("offset changed while idle");
  property p_ser_shift;
    @(posedge mclk) disable iff (!rst_n)
      up_w && ser_q && !threshold_load_n && !serial_prog_en_n
      |=> ##1 full_thr_out[DCF_TW-1] == $past(fall_through, 2);
  endproperty
  a_ser_shift: assert property (p_ser_shift) else $error("serial bit not shifted in");
  property p_empty_ae;
    @(posedge read_clk) disable iff (!rst_n)
      up_r && !ft_q && !empty_n ##1 !empty_n |-> !$past(almost_empty_n);
  endproperty
  a_empty_ae: assert property (p_empty_ae) else $error("empty without almost empty");
  property p_valid_hold;
    @(posedge read_clk) disable iff (!rst_n)
      up_r && ft_q && !empty_n && read_req_n |=> !empty_n;
  endproperty
  a_valid_hold: assert property (p_valid_hold) else $error("valid dropped without read");
  c_full: cover property (@(posedge mclk) disable iff (!rst_n) up_w && full_w);
  c_fall: cover property (@(posedge read_clk) disable iff (!rst_n) ft_q && $fell(empty_n));
  c_ser: cover property (@(posedge mclk) disable iff (!rst_n) ser_q && !serial_prog_en_n);
endmodule

bind dcf_top dcf_checker dcf_checker_inst (.*);

// ---- verif/dcf_reader.sv ----
// reader partner: requests words on the read clock with random stalls
`timescale 1ns/100ps
module dcf_reader (
  input  wire logic read_clk,
  input  wire logic en,
  output logic      read_req_n
);
  // every word requested in standard mode; fall-through presents the first word after empty without a request
  initial begin
    read_req_n = 1'b1;
    forever @(posedge read_clk) read_req_n <= #1 !(en && ($urandom % 3 != 0));
  end
endmodule

// ---- verif/tb.sv ----
// self-checking bench for the dual-clock fifo
`timescale 1ns/100ps
module tb;
  import dcf_pkg::*;
  logic              mclk, read_clk, rst_n, write_req_n, threshold_load_n;
  logic              serial_prog_en_n, fall_through, output_drive_n, read_req_n;
  logic              rd_en, ft, pr, pe;
  logic              empty_n, full_n, almost_empty_n, almost_full_n, half_full_n;
  logic [DCF_DW-1:0] write_data, read_data_out, read_data_oe;
  logic [DCF_DW-1:0] sl[4];
  logic [DCF_DW-1:0] exp_q[$];
  logic [DCF_TW-1:0] empty_thr_out, full_thr_out, thr_n, thr_m;
  logic [27:0]       vec;
  int                num_errors, compares, wcnt, cyc, k;

  dcf_top dcf_top_inst (.*);
  dcf_reader dcf_reader_inst (.read_clk, .en(rd_en), .read_req_n);

  initial begin mclk = 0; forever #4 mclk = ~mclk; end
  initial begin read_clk = 0; #3.3; forever #32 read_clk = ~read_clk; end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 80000) begin num_errors++; close_out; end
  end

  // ===================================================================
  // compare and report
  // ===================================================================
  task chk_word(input logic [DCF_DW-1:0] e, input logic [DCF_DW-1:0] g);
    compares++;
    if (e !== g) begin num_errors++; $display("Error %0t exp %h got %h", $time, e, g); end
  endtask
  task chk_flag(input logic e, input logic g);
    compares++;
    if (e !== g) begin num_errors++; $display("Error %0t exp %h got %h", $time, e, g); end
  endtask
  task chk_thr(input logic [DCF_TW-1:0] e, input logic [DCF_TW-1:0] g);
    compares++;
    if (e !== g) begin num_errors++; $display("Error %0t exp %h got %h", $time, e, g); end
  endtask
  task close_out;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // watcher: a delivered word is checked against the oldest note
  always @(posedge read_clk) begin
    pr = read_req_n;
    pe = empty_n;
    #2;
    if (ft ? (!empty_n && (pe || !pr)) : (!pr && pe))
      chk_word(exp_q.size() ? exp_q.pop_front() : ~read_data_out, read_data_out);
  end

  // ===================================================================
  // drivers
  // ===================================================================
  task wm(input int n); repeat (n) @(posedge mclk); #1; endtask
  task wrd(input int n); repeat (n) @(posedge read_clk); #1; endtask
  task wr(input int n);
    repeat (n) begin
      @(posedge mclk) #1 write_req_n = 0;
      write_data = DCF_DW'($urandom);
      exp_q.push_back(write_data);
    end
    @(posedge mclk) #1 write_req_n = 1;
    wcnt += n;
  endtask
  task reset(input logic f, input logic l);
    rst_n = 0; fall_through = f; threshold_load_n = l; ft = f;
    rd_en = 0; wcnt = 0; exp_q.delete();
    wrd(3);
    @(posedge mclk) #1 rst_n = 1;
    wm(2);
    threshold_load_n = 1;
    wrd(8);
  endtask
  task prog;
    vec = {thr_m, thr_n};
    sl = '{thr_n[8:0], 9'(thr_n[13:9]), thr_m[8:0], 9'(thr_m[13:9])};
    threshold_load_n = 0;
    serial_prog_en_n = ft;
    for (int i = 0; i < (ft ? 4 : 28); i++) begin
      if (ft) begin write_req_n = 0; write_data = sl[i]; end
      else fall_through = vec[i];
      wm(1);
    end
    write_req_n = 1;
    serial_prog_en_n = 1;
    repeat (4) begin fall_through = 1'($urandom); wm(1); end
    threshold_load_n = 1;
    wm(3);
    chk_thr(thr_n, empty_thr_out);
    chk_thr(thr_m, full_thr_out);
  endtask
  task step(input int tgt, input int f);
    logic act;
    act = !(f == 2 && ft);
    wr(tgt - 1 - wcnt); wm(8);
    chk_flag(act, f == 0 ? half_full_n : f == 1 ? almost_full_n : full_n);
    wr(1); wm(8);
    chk_flag(!act, f == 0 ? half_full_n : f == 1 ? almost_full_n : full_n);
  endtask

  // ===================================================================
  // main sequence
  // ===================================================================
  initial begin
    rst_n = 0; write_req_n = 1; write_data = '0; threshold_load_n = 1;
    serial_prog_en_n = 1; fall_through = 0; output_drive_n = 0; rd_en = 0; ft = 0;
    void'($urandom(39723));
    for (int md = 0; md < 2; md++) begin
      reset(md[0], !md[0]);
      chk_thr(md ? DCF_THR_DEF_PAR : DCF_THR_DEF_SER, empty_thr_out);
      chk_thr(md ? DCF_THR_DEF_PAR : DCF_THR_DEF_SER, full_thr_out);
      thr_n = 14'(1 + $urandom % 12);
      thr_m = 14'(1 + $urandom % 4000);
      prog;
      wr(1); k = 0;
      while (empty_n !== !ft && k < 8) begin wrd(1); k++; end
      chk_flag(1'b1, k > 2 && k < 5);
      wr(int'(thr_n) + ft - wcnt); wrd(8);
      chk_flag(1'b0, almost_empty_n);
      wr(1); wrd(8);
      chk_flag(1'b1, almost_empty_n);
      rd_en = 1; k = 0;
      while (exp_q.size() != 0 && k < 200) begin wrd(1); k++; end
      wrd(10); rd_en = 0; wrd(4);
      chk_flag(1'b1, exp_q.size() == 0);
      chk_flag(ft, empty_n);
      wcnt = 0;
      step(int'(DCF_HALF) + 1 + ft, 0);
      step(int'(DCF_DEPTH) + ft - int'(thr_m), 1);
      step(int'(DCF_DEPTH) + ft, 2);
      k = exp_q.size(); rd_en = 1;
      repeat (50) if (exp_q.size() == k) wrd(1);
      rd_en = 0; wm(12);
      chk_flag(!ft, full_n);
    end
    output_drive_n = 1; wrd(8);
    chk_word('0, read_data_oe);
    output_drive_n = 0; wrd(8);
    chk_word('1, read_data_oe);
    close_out;
  end
endmodule
